// [inc/srs_pkg.sv]
`default_nettype none

package srs_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS        = 4;
  localparam int EXT_MIN_WIDTH_NS     = 2500;
  localparam int EXT_MIN_CYCLES       = (EXT_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BROWNOUT_MIN_DURATION_NS = 2000;
  localparam int BROWNOUT_MIN_CYCLES  = (BROWNOUT_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_TIMEOUT_BASE_NS = 16000;
  localparam int RESET_TIMEOUT_BASE_CYCLES = (RESET_TIMEOUT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int FILT_CNT_W           = 16;
  localparam int DELAY_CNT_W          = 20;
  localparam int START_W              = 2;
  localparam int CLKSRC_W             = 4;

  // Register map
  localparam logic [7:0] RESET_CAUSE_OFFSET       = 8'h54;
  localparam logic [7:0] RESET_CAUSE_RESET        = 8'h00;
  localparam logic [7:0] PWR_RED_SECOND_OFFSET    = 8'h65;
  localparam logic [7:0] PWR_RED_SECOND_RESET     = 8'h00;
  localparam int         TIMER3_STOP_BIT          = 0;
  localparam int         CAUSE_POR_BIT            = 0;
  localparam int         CAUSE_EXT_BIT            = 1;
  localparam int         CAUSE_BROWNOUT_BIT       = 2;
  localparam int         CAUSE_WDT_BIT            = 3;
  localparam int         CAUSE_SCAN_BIT           = 4;

  typedef enum logic [2:0] {
    SRS_ST_HELD  = 3'b001,
    SRS_ST_DELAY = 3'b010,
    SRS_ST_RUN   = 3'b100
  } srs_fsm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } srs_bus_req_t;

  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    logic [FILT_CNT_W-1:0] count;
    logic                  qual;
  } srs_filt_state_t;

  typedef struct packed {
    logic                   por_s1;
    logic                   por_s2;
    logic                   scan_s1;
    logic                   scan_s2;
    logic                   wdt_last;
    logic                   wdt_pulse;
    srs_fsm_t               fsm;
    logic [DELAY_CNT_W-1:0] count;
    logic                   core_reset;
    logic [7:0]             pwr_red;
    logic [7:0]             cause;
    logic                   bandgap;
    logic [7:0]             rdata;
  } srs_state_t;

endpackage : srs_pkg

`default_nettype wire

// [hdl/srs_width_filter.sv]
`default_nettype none

// Two-flop sync, then qualifies a level only after it held MIN_CYCLES
module srs_width_filter
  import srs_pkg::*;
#(
  parameter int MIN_CYCLES = 1
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic raw_i,
  output logic      qual_o
);

  localparam logic [FILT_CNT_W-1:0] LIMIT = FILT_CNT_W'(MIN_CYCLES);

  srs_filt_state_t st;
  srs_filt_state_t next_st;

  always_comb begin
    next_st       = st;
    next_st.sync1 = raw_i;
    next_st.sync2 = st.sync1;
    if (!st.sync2) begin
      next_st.count = '0;
      next_st.qual  = 1'b0;
    end else if (st.count == LIMIT) begin
      next_st.qual  = 1'b1;
    end else begin
      next_st.count = st.count + FILT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign qual_o = st.qual;

endmodule : srs_width_filter

`default_nettype wire

// [hdl/srs_sequencer.sv]
`default_nettype none

module srs_sequencer
  import srs_pkg::*;
#(
  parameter int TIMEOUT_BASE_CYCLES = RESET_TIMEOUT_BASE_CYCLES,
  parameter int EXT_MIN_CYC         = EXT_MIN_CYCLES,
  parameter int BROWNOUT_MIN_CYC    = BROWNOUT_MIN_CYCLES
) (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                por_low_i,
  input  wire logic                ext_reset_n_i,
  input  wire logic                external_reset_disable_i,
  input  wire logic                brownout_low_i,
  input  wire logic                brownout_enable_i,
  input  wire logic                scan_reset_i,
  input  wire logic                wdt_expire_i,
  input  wire logic                wdt_sysrst_mode_i,
  input  wire logic [START_W-1:0]  startup_time_select_i,
  input  wire logic [CLKSRC_W-1:0] clock_source_select_i,
  input  wire logic                comparator_bandgap_select_i,
  input  wire logic                adc_enable_i,
  input  wire srs_bus_req_t        bus_i,
  output logic [7:0]               reg_rdata_o,
  output logic                     core_reset_o,
  output logic                     io_reset_o,
  output logic                     timer3_clock_stop_o,
  output logic                     bandgap_enable_o
);

  srs_state_t             st;
  srs_state_t             next_st;
  logic                   ext_q;
  logic                   brownout_q;
  logic                   ext_req;
  logic                   brownout_req;
  logic                   req;
  logic                   async_src;
  logic                   io_hold;
  logic [DELAY_CNT_W-1:0] tout_last;
  logic [2:0]             tout_shift;

  // Pin width qualification; pulses shorter than this may be missed
  srs_width_filter #(
    .MIN_CYCLES (EXT_MIN_CYC)
  ) u_ext_filter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (~ext_reset_n_i),
    .qual_o    (ext_q)
  );

  // Supply dips shorter than the detection time never qualify
  srs_width_filter #(
    .MIN_CYCLES (BROWNOUT_MIN_CYC)
  ) u_brownout_filter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (brownout_low_i),
    .qual_o    (brownout_q)
  );

  assign ext_req = ext_q & ~external_reset_disable_i;
  assign brownout_req = brownout_q & brownout_enable_i;

  // Request is the OR of every enabled, qualified source
  assign req = st.por_s2 | ext_req | brownout_req | st.scan_s2 | st.wdt_pulse;

  // Delay length from start-up and clock-source selections
  assign tout_shift = {1'b0, startup_time_select_i} + {2'b00, clock_source_select_i[0]};
  assign tout_last  = DELAY_CNT_W'(TIMEOUT_BASE_CYCLES) * (DELAY_CNT_W'(1) << tout_shift)
                      - DELAY_CNT_W'(1);

  always_comb begin
    next_st          = st;
    next_st.por_s1   = por_low_i;
    next_st.por_s2   = st.por_s1;
    next_st.scan_s1  = scan_reset_i;
    next_st.scan_s2  = st.scan_s1;
    next_st.wdt_last = wdt_expire_i;

    // Exactly one clock per expiry, and only in system-reset mode
    next_st.wdt_pulse = wdt_expire_i & ~st.wdt_last & wdt_sysrst_mode_i;

    unique case (st.fsm)
      SRS_ST_HELD: begin
        next_st.count = '0;
        if (!req) begin
          next_st.fsm = SRS_ST_DELAY;
        end
      end
      SRS_ST_DELAY: begin
        if (req) begin
          next_st.fsm   = SRS_ST_HELD;
          next_st.count = '0;
        end else if (st.count == tout_last) begin
          next_st.fsm   = SRS_ST_RUN;
        end else begin
          next_st.count = st.count + DELAY_CNT_W'(1);
        end
      end
      SRS_ST_RUN: begin
        if (req) begin
          next_st.fsm = SRS_ST_HELD;
        end
      end
    endcase
    next_st.core_reset = (next_st.fsm != SRS_ST_RUN);

    // Registers: writes only while the core runs
    if (st.core_reset) begin
      next_st.pwr_red = PWR_RED_SECOND_RESET;
    end else if (bus_i.we && bus_i.addr == PWR_RED_SECOND_OFFSET) begin
      next_st.pwr_red = bus_i.wdata;
    end

    // Cause flags: writing zero clears, a coincident event still sets
    if (!st.core_reset && bus_i.we && bus_i.addr == RESET_CAUSE_OFFSET) begin
      next_st.cause = st.cause & bus_i.wdata;
    end
    if (ext_req) begin
      next_st.cause[CAUSE_EXT_BIT] = 1'b1;
    end
    if (brownout_req) begin
      next_st.cause[CAUSE_BROWNOUT_BIT] = 1'b1;
    end
    if (st.scan_s2) begin
      next_st.cause[CAUSE_SCAN_BIT] = 1'b1;
    end
    if (st.wdt_pulse) begin
      next_st.cause[CAUSE_WDT_BIT] = 1'b1;
    end
    // Power-on clears all other causes
    if (st.por_s2) begin
      next_st.cause = RESET_CAUSE_RESET;
      next_st.cause[CAUSE_POR_BIT] = 1'b1;
    end

    // Reference runs only when something needs it
    next_st.bandgap = brownout_enable_i | comparator_bandgap_select_i | adc_enable_i;

    unique case (bus_i.addr)
      PWR_RED_SECOND_OFFSET: next_st.rdata = st.pwr_red;
      RESET_CAUSE_OFFSET:    next_st.rdata = st.cause;
      default:               next_st.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st            <= '0;
      st.fsm        <= SRS_ST_HELD;
      st.core_reset <= 1'b1;
      st.pwr_red    <= PWR_RED_SECOND_RESET;
      st.cause      <= RESET_CAUSE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Port reset must not wait for a clock, so raw pin and supply set it directly
  assign async_src = por_low_i | (~ext_reset_n_i & ~external_reset_disable_i);

  always_ff @(posedge clk_i or posedge async_src) begin
    if (async_src) begin
      io_hold <= 1'b1;
    end else if (sys_rst_i) begin
      io_hold <= 1'b1;
    end else begin
      io_hold <= next_st.core_reset;
    end
  end

  assign reg_rdata_o         = st.rdata;
  assign core_reset_o        = st.core_reset;
  assign io_reset_o          = io_hold;
  assign timer3_clock_stop_o = st.pwr_red[TIMER3_STOP_BIT];
  assign bandgap_enable_o    = st.bandgap;

endmodule : srs_sequencer

`default_nettype wire

// [verification/srs_sequencer_chk.sv]
`default_nettype none
module srs_sequencer_chk
  import srs_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         sys_rst_i,
  input wire logic         por_low_i,
  input wire logic         scan_reset_i,
  input wire logic         wdt_expire_i,
  input wire logic         wdt_sysrst_mode_i,
  input wire logic         brownout_enable_i,
  input wire logic         comparator_bandgap_select_i,
  input wire logic         adc_enable_i,
  input wire srs_bus_req_t bus_i,
  input wire logic         core_reset_o,
  input wire logic         io_reset_o,
  input wire logic         timer3_clock_stop_o,
  input wire logic         bandgap_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_io_async: assert property (por_low_i |-> io_reset_o)
    else $error("port reset missing under supply fault");
  a_por_holds: assert property (por_low_i [*5] |-> core_reset_o)
    else $error("supply fault not holding core reset");
  a_scan_holds: assert property (scan_reset_i [*5] |-> core_reset_o)
    else $error("scan bit not holding core reset");
  a_wdt_resets: assert property ($rose(wdt_expire_i) && wdt_sysrst_mode_i |-> ##[1:3] core_reset_o)
    else $error("watchdog expiry gave no reset");
  a_stretch_min: assert property ($rose(core_reset_o) |-> core_reset_o [*4])
    else $error("core reset shorter than the delay");
  a_bandgap_gate: assert property (1'h1 |=> bandgap_enable_o ==
      $past(brownout_enable_i || comparator_bandgap_select_i || adc_enable_i))
    else $error("reference enable wrong");
  a_stop_write: assert property (bus_i.we && bus_i.addr == PWR_RED_SECOND_OFFSET && !core_reset_o
      |=> timer3_clock_stop_o == $past(bus_i.wdata[TIMER3_STOP_BIT]))
    else $error("timer stop bit not written");
  a_stop_cleared: assert property (core_reset_o |=> !timer3_clock_stop_o)
    else $error("timer stop bit survives reset");
  a_io_release: assert property ($fell(core_reset_o) |-> !io_reset_o)
    else $error("port reset outlives core reset");
endmodule : srs_sequencer_chk
bind srs_sequencer srs_sequencer_chk chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_low_i(por_low_i), .scan_reset_i(scan_reset_i),
  .wdt_expire_i(wdt_expire_i), .wdt_sysrst_mode_i(wdt_sysrst_mode_i), .brownout_enable_i(brownout_enable_i),
  .comparator_bandgap_select_i(comparator_bandgap_select_i), .adc_enable_i(adc_enable_i), .bus_i(bus_i),
  .core_reset_o(core_reset_o), .io_reset_o(io_reset_o), .timer3_clock_stop_o(timer3_clock_stop_o),
  .bandgap_enable_o(bandgap_enable_o));
`default_nettype wire

// [verification/srs_partner.sv]
`default_nettype none
// Supply monitors, reset pin, watchdog and scan bit; pin idles high
module srs_partner (
  input  wire logic       clk_i,
  input  wire logic [4:0] cmd_i,
  output logic            por_low_o,
  output logic            ext_reset_n_o,
  output logic            brownout_low_o,
  output logic            scan_reset_o,
  output logic            wdt_expire_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {por_low_o, ext_reset_n_o, brownout_low_o, scan_reset_o, wdt_expire_o} = 5'h08;
  always @(posedge clk_i) {por_low_o, ext_reset_n_o, brownout_low_o, scan_reset_o, wdt_expire_o} <= cmd_i ^ 5'h08;
endmodule : srs_partner
`default_nettype wire

// [verification/system_reset_sequencer_test.sv]
`default_nettype none
module system_reset_sequencer_test
  import srs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 4;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, external_reset_disable_i = 1'h0, brownout_enable_i = 1'h0;
  logic wdt_sysrst_mode_i = 1'h0, comparator_bandgap_select_i = 1'h0, adc_enable_i = 1'h0;
  logic [START_W-1:0]  startup_time_select_i = 2'h0;
  logic [CLKSRC_W-1:0] clock_source_select_i = 4'h0;
  logic [4:0]         cmd = 5'h00;
  srs_bus_req_t       bus_i = '0;
  logic [7:0]         reg_rdata_o, d;
  logic por_low_i, ext_reset_n_i, brownout_low_i, scan_reset_i, wdt_expire_i;
  logic core_reset_o, io_reset_o, timer3_clock_stop_o, bandgap_enable_o;
  int bad_count = 0, n_tests = 0, n0, n1;
  always #2 clk_i = ~clk_i;
  srs_partner mdl (.clk_i(clk_i), .cmd_i(cmd), .por_low_o(por_low_i), .ext_reset_n_o(ext_reset_n_i),
    .brownout_low_o(brownout_low_i), .scan_reset_o(scan_reset_i), .wdt_expire_o(wdt_expire_i));
  srs_sequencer #(.TIMEOUT_BASE_CYCLES(BASE), .EXT_MIN_CYC(2), .BROWNOUT_MIN_CYC(2)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_low_i(por_low_i), .ext_reset_n_i(ext_reset_n_i),
    .external_reset_disable_i(external_reset_disable_i), .brownout_low_i(brownout_low_i),
    .brownout_enable_i(brownout_enable_i), .scan_reset_i(scan_reset_i), .wdt_expire_i(wdt_expire_i),
    .wdt_sysrst_mode_i(wdt_sysrst_mode_i), .startup_time_select_i(startup_time_select_i),
    .clock_source_select_i(clock_source_select_i), .comparator_bandgap_select_i(comparator_bandgap_select_i),
    .adc_enable_i(adc_enable_i), .bus_i(bus_i), .reg_rdata_o(reg_rdata_o), .core_reset_o(core_reset_o),
    .io_reset_o(io_reset_o), .timer3_clock_stop_o(timer3_clock_stop_o), .bandgap_enable_o(bandgap_enable_o));
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic pulse(input logic [4:0] c, input int n);
    @(posedge clk_i) cmd <= c;
    repeat (n) @(posedge clk_i);
    cmd <= 5'h00;
  endtask : pulse
  task automatic settle();
    for (int i = 0; i < 300 && core_reset_o !== 1'h0; i++) tick(1);
    check("release", {7'h00, core_reset_o}, 8'h00);
  endtask : settle
  task automatic watch(input string what, input logic exp);
    logic seen;
    seen = 1'h0;
    for (int i = 0; i < 12; i++) begin
      tick(1);
      seen |= core_reset_o;
    end
    check(what, {7'h00, seen}, {7'h00, exp});
    settle();
  endtask : watch
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i) bus_i <= '{a, 8'h00, 1'h0};
    tick(1);
    d = reg_rdata_o;
  endtask : rd
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_i) bus_i <= '{a, v, 1'h1};
    @(posedge clk_i) bus_i.we <= 1'h0;
  endtask : wr
  task automatic t_regs();
    settle();
    rd(PWR_RED_SECOND_OFFSET); check("power reduction", d, 8'h00);
    rd(8'h40); check("unmapped", d, 8'h00);
    wr(PWR_RED_SECOND_OFFSET, 8'h01);
    tick(1); check("timer stop", {7'h00, timer3_clock_stop_o}, 8'h01);
    rd(PWR_RED_SECOND_OFFSET); check("power reduction", d, 8'h01);
    wr(PWR_RED_SECOND_OFFSET, 8'h00);
    tick(1); check("timer run", {7'h00, timer3_clock_stop_o}, 8'h00);
  endtask : t_regs
  task automatic tmeas(input logic [1:0] s, output int n);
    settle();
    @(posedge clk_i) startup_time_select_i <= s;
    pulse(5'h10, 4);
    #1 check("port reset", {7'h00, io_reset_o}, 8'h01);
    for (n = 0; n < 300 && core_reset_o !== 1'h0; n++) tick(1);
  endtask : tmeas
  task automatic t_timeout();
    tmeas(2'h0, n0);
    tmeas(2'h1, n1);
    check("delay step", 8'(n1 - n0), 8'(BASE));
    @(posedge clk_i) clock_source_select_i <= 4'h1;
    tmeas(2'h0, n1);
    check("clock select step", 8'(n1 - n0), 8'(BASE));
  endtask : t_timeout
  task automatic t_sources();
    pulse(5'h01, 1); watch("wdt off", 1'h0);
    @(posedge clk_i) wdt_sysrst_mode_i <= 1'h1;
    pulse(5'h01, 1); watch("wdt on", 1'h1);
    rd(RESET_CAUSE_OFFSET); check("wdt flag", d & 8'h08, 8'h08);
    wr(RESET_CAUSE_OFFSET, 8'h00);
    rd(RESET_CAUSE_OFFSET); check("flag clear", d, 8'h00);
    pulse(5'h08, 1); watch("short pin", 1'h0);
    @(posedge clk_i) external_reset_disable_i <= 1'h1;
    pulse(5'h08, 6); watch("pin disabled", 1'h0);
    @(posedge clk_i) external_reset_disable_i <= 1'h0;
    pulse(5'h08, 6); watch("pin", 1'h1);
    pulse(5'h04, 6); watch("brownout off", 1'h0);
    @(posedge clk_i) brownout_enable_i <= 1'h1;
    pulse(5'h04, 1); watch("brownout dip", 1'h0);
    pulse(5'h04, 6); watch("brownout", 1'h1);
    pulse(5'h02, 20); watch("scan", 1'h1);
  endtask : t_sources
  task automatic t_bandgap();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i) {brownout_enable_i, comparator_bandgap_select_i, adc_enable_i} <= 3'(i);
      tick(2); check("bandgap", {7'h00, bandgap_enable_o}, {7'h00, i != 0});
    end
  endtask : t_bandgap
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    t_regs();
    t_timeout();
    t_sources();
    t_bandgap();
    print_verdict();
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
endmodule : system_reset_sequencer_test
`default_nettype wire
